/* shared/lps_pkg.sv */
// lps_pkg: constants, state encodings and carrier structs of the led power-up sequencer.
// assumes a single 250 MHz system clock; analog comparators arrive as async levels.
package lps_pkg;

  // ----------------------------------------------------------------
  // clock and sizes
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int NUM_CH  = 4;
  localparam int CNT_W   = 16;
  localparam int GAP_W   = 10;
  localparam int LOW_W   = 11;
  localparam int DIV_W   = 8;

  // ----------------------------------------------------------------
  // timing, ns times in ns then in cycles; switching-cycle counts and the divider as they are
  // ----------------------------------------------------------------
  localparam int MIN_HIGH_NS = 750;
  localparam logic [CNT_W-1:0] MIN_HIGH_CYC = CNT_W'((MIN_HIGH_NS * CLK_MHZ + 999) / 1000);
  localparam int PIN_LOW_NS = 7000;
  localparam logic [LOW_W-1:0] PIN_LOW_CYC = LOW_W'((PIN_LOW_NS * CLK_MHZ) / 1000);
  // sync edges further apart than this mean the external clock is gone
  localparam int SYNC_GAP_NS = 2000;
  localparam logic [GAP_W-1:0] SYNC_GAP_CYC = GAP_W'((SYNC_GAP_NS * CLK_MHZ) / 1000);
  // detect delay in switching cycles, inside the 3000..4000 window
  localparam logic [CNT_W-1:0] DETECT_TICKS = 16'h0DAC;
  // enable-low time to shutdown, in switching cycles
  localparam int EN_LOW_TICKS = 32750;
  // internal resistor-set oscillator divider, 2 MHz at 250 MHz
  localparam int OSC_DIV = 125;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_QUALIFY, ST_GATE_WAIT, ST_DETECT_ARM, ST_DETECT_DELAY,
    ST_SHORT_HOLD, ST_SOFTSTART, ST_RUN, ST_PIN_OFF
  } lps_state_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              enable;
    logic              lockoutOk;
    logic              gateReady;
    logic              sinkVoltsOk;
    logic [NUM_CH-1:0] ledAbove;
    logic [NUM_CH-1:0] ledShort;
    logic [NUM_CH-1:0] ledInUse;
  } lps_sense_s;

  typedef struct packed {
    logic              switchEnable;
    logic              switchTick;
    logic              gateDrive;
    logic [NUM_CH-1:0] sinkEnable;
    logic              softstartSinkCurrent;
    logic              softstartSwitchLimit;
    logic              fullSwitchLimit;
    logic              shutdown;
  } lps_ctrl_s;

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    logic [GAP_W-1:0] gap;
    logic [LOW_W-1:0] lowCnt;
    logic [DIV_W-1:0] div;
    logic             ext;
    logic             heldLow;
    logic             high;
    logic             tick;
  } lps_sync_s;

endpackage

/* src/lps_sequencer.sv */
// lps_sequencer: start-up and clocking sequencer of a four-channel led backlight driver.
// assumes comparator levels arrive asynchronously; analog regulation lives outside.
//
// Overview of operation
// - start only after enable high for min time with supply above lockout level
// - never power up while the frequency-set/sync pin is held low
// - run a system fault check before any led sink is enabled
// - drive disconnect gate first; start led detect when gate reaches its level
// - after pin exceeds detect level, wait 3000..4000 switching cycles before deciding
// - classify pins: shorted halts start-up, unused removed, in use kept
// - hold off soft start while shorted; recheck the pin after release
// - an unused channel never drives a sink nor joins the loop
// - soft start uses soft-start sink current and reduced switch limit
// - on enough sink voltage go to regulation current and full limit
// - a sync pin shorted low during operation shuts the device down
// - attempt power-up only with pin released high or sync clock detected
// - on sync loss fall back to the resistor-set frequency
// - switching may halt at most about 7 us during changeover
// - sync pin low longer than 7 us enters shutdown
// - in that shutdown stop switching, open disconnect switch, sinks off
// - pin released after that low period resumes into soft start; before the channel check is done it returns to idle instead
// - enable low for 32750 switching cycles shuts the device down
`timescale 1ns/10ps
`default_nettype none

module lps_sequencer #(
  parameter int EnLowTicks = lps_pkg::EN_LOW_TICKS,
  parameter int OscDiv     = lps_pkg::OSC_DIV
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // pads and comparators, asynchronous
  input  wire lps_pkg::lps_sense_s senseIn,
  input  wire logic               freqSetSyncPin,
  // power stage control
  output var  lps_pkg::lps_ctrl_s ctrlOut,
  // status
  output var  logic [lps_pkg::NUM_CH-1:0] chanUsed,
  output var  logic               useExternalClock
);

  localparam int NUM_CH = lps_pkg::NUM_CH;
  localparam int CNT_W  = lps_pkg::CNT_W;

  typedef struct packed {
    lps_pkg::lps_state_e st;
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    enLow;
    logic [NUM_CH-1:0]   used;
    logic                checked;
    logic                extSeen;
    lps_pkg::lps_sense_s meta;
    lps_pkg::lps_sense_s sense;
    lps_pkg::lps_ctrl_s  out;
  } lps_seq_s;

  lps_seq_s q;
  lps_seq_s d;

  logic tick;
  logic extActive;
  logic pinHigh;
  logic pinHeldLow;

  // ----------------------------------------------------------------
  // sync pin watcher and switching clock
  // ----------------------------------------------------------------
  lps_sync_clock #(
    .OscDiv (OscDiv)
  ) u_sync (
    .clk            (clk),
    .rst_n          (rst_n),
    .freqSetSyncPin (freqSetSyncPin),
    .switchTick     (tick),
    .extActive      (extActive),
    .pinHigh        (pinHigh),
    .pinHeldLow     (pinHeldLow)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic en;
  logic lockOk;
  logic pinOk;
  logic detectDone;
  logic enLowDone;

  always_comb begin
    en         = q.sense.enable;
    lockOk     = q.sense.lockoutOk;
    // released pin or a detected sync clock lets start-up go on
    pinOk      = pinHigh || extActive;
    detectDone = tick && (q.cnt == lps_pkg::DETECT_TICKS - 1'b1);
    enLowDone  = tick && (q.enLow == CNT_W'(EnLowTicks - 1));
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.meta  = senseIn;
    d.sense = q.meta;
    d.extSeen = extActive;

    // enable-low timeout runs in switching cycles while powered
    if (en || q.st == lps_pkg::ST_IDLE) begin
      d.enLow = '0;
    end else if (tick) begin
      d.enLow = q.enLow + 1'b1;
    end

    case (q.st)
      lps_pkg::ST_IDLE: begin
        d.cnt = '0;
        if (en && lockOk && pinOk) begin
          d.st = lps_pkg::ST_QUALIFY;
        end
      end
      lps_pkg::ST_QUALIFY: begin
        // first high pulse must last its minimum width
        if (!(en && lockOk && pinOk)) begin
          d.st = lps_pkg::ST_IDLE;
        end else if (q.cnt == lps_pkg::MIN_HIGH_CYC - 1'b1) begin
          d.st  = lps_pkg::ST_GATE_WAIT;
          d.cnt = '0;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      lps_pkg::ST_GATE_WAIT: begin
        if (q.sense.gateReady) begin
          d.st = lps_pkg::ST_DETECT_ARM;
        end
      end
      lps_pkg::ST_DETECT_ARM: begin
        d.cnt = '0;
        if (|q.sense.ledAbove) begin
          d.st = lps_pkg::ST_DETECT_DELAY;
        end
      end
      lps_pkg::ST_DETECT_DELAY: begin
        // counts switching cycles, so detect time scales with frequency
        if (detectDone) begin
          d.cnt = '0;
          if (|q.sense.ledShort) begin
            d.st = lps_pkg::ST_SHORT_HOLD;
          end else begin
            d.used    = q.sense.ledInUse;
            d.checked = 1'b1;
            d.st      = lps_pkg::ST_SOFTSTART;
          end
        end else if (tick) begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      lps_pkg::ST_SHORT_HOLD: begin
        // a released pin goes through the full detect delay again
        d.cnt = '0;
        if (!(|q.sense.ledShort)) begin
          d.st = lps_pkg::ST_DETECT_DELAY;
        end
      end
      lps_pkg::ST_SOFTSTART: begin
        if (q.sense.sinkVoltsOk) begin
          d.st = lps_pkg::ST_RUN;
        end
      end
      lps_pkg::ST_RUN: begin
        d.st = lps_pkg::ST_RUN;
      end
      lps_pkg::ST_PIN_OFF: begin
        // a finished check is kept, so release resumes in soft start
        if (!pinHeldLow && pinOk) begin
          d.st = q.checked ? lps_pkg::ST_SOFTSTART : lps_pkg::ST_IDLE;
        end
      end
      default: begin
        d.st = lps_pkg::ST_IDLE;
      end
    endcase

    // shutdown causes override the step above
    if (q.st != lps_pkg::ST_IDLE) begin
      if (enLowDone || !lockOk) begin
        d.st      = lps_pkg::ST_IDLE;
        d.checked = 1'b0;
        d.used    = '0;
      end else if (pinHeldLow && q.st != lps_pkg::ST_PIN_OFF) begin
        d.st = lps_pkg::ST_PIN_OFF;
      end
    end

    // outputs follow the next state so they leave straight from flops
    d.out = '0;
    d.out.shutdown = (d.st == lps_pkg::ST_IDLE) || (d.st == lps_pkg::ST_PIN_OFF);
    d.out.gateDrive = !d.out.shutdown && (d.st != lps_pkg::ST_QUALIFY);
    if (d.st == lps_pkg::ST_SOFTSTART || d.st == lps_pkg::ST_RUN) begin
      // enable low dims: sinks and switching stop, state is kept
      d.out.sinkEnable   = d.used & {NUM_CH{d.sense.enable}};
      d.out.switchEnable = d.sense.enable;
      d.out.switchTick   = d.sense.enable && tick;
      d.out.softstartSinkCurrent = (d.st == lps_pkg::ST_SOFTSTART);
      d.out.softstartSwitchLimit = (d.st == lps_pkg::ST_SOFTSTART);
      d.out.fullSwitchLimit      = (d.st == lps_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: lps_pkg::ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign ctrlOut          = q.out;
  assign chanUsed         = q.used;
  assign useExternalClock = q.extSeen;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence qualifyEnd_s;
    q.st == lps_pkg::ST_QUALIFY ##1 q.st == lps_pkg::ST_GATE_WAIT;
  endsequence

  qualifyTime_a: assert property (qualifyEnd_s
                                  |-> $past(q.cnt) == lps_pkg::MIN_HIGH_CYC - 1'b1)
    else $error("left qualify without a held enable");
  pinLowBlock_a: assert property (q.st == lps_pkg::ST_IDLE && !pinOk
                                  |=> q.st == lps_pkg::ST_IDLE)
    else $error("power-up began with sync pin low");
  noSinkEarly_a: assert property (|ctrlOut.sinkEnable |-> q.checked)
    else $error("sink enabled before the channel check");
  gateFirst_a: assert property (q.st == lps_pkg::ST_DETECT_ARM |-> ctrlOut.gateDrive)
    else $error("detect armed without gate drive");
  detectLen_a: assert property ($rose(q.checked)
                                |-> $past(q.cnt) == lps_pkg::DETECT_TICKS - 1'b1)
    else $error("channel decision before the detect delay");
  shortHalt_a: assert property (q.st == lps_pkg::ST_DETECT_DELAY && detectDone
                                && |q.sense.ledShort && !pinHeldLow && lockOk && !enLowDone
                                |=> q.st == lps_pkg::ST_SHORT_HOLD)
    else $error("shorted pin did not halt start-up");
  shortBlock_a: assert property (q.st == lps_pkg::ST_SHORT_HOLD
                                 |=> q.st != lps_pkg::ST_SOFTSTART)
    else $error("soft start entered from a short");
  unusedOff_a: assert property ((ctrlOut.sinkEnable & ~q.used) == '0)
    else $error("unused channel sink enabled");
  softLimit_a: assert property (q.st == lps_pkg::ST_SOFTSTART
                                |-> ctrlOut.softstartSwitchLimit && !ctrlOut.fullSwitchLimit)
    else $error("soft start without reduced limit");
  runFull_a: assert property (q.st == lps_pkg::ST_RUN
                              |-> ctrlOut.fullSwitchLimit && !ctrlOut.softstartSinkCurrent)
    else $error("regulation without full limit");
  pinOffQuiet_a: assert property ($rose(pinHeldLow) && q.st != lps_pkg::ST_IDLE
                                  |=> ctrlOut.shutdown && !ctrlOut.switchEnable
                                  && !ctrlOut.gateDrive && ctrlOut.sinkEnable == '0)
    else $error("held-low pin did not shut down");
  enLowShut_a: assert property (q.st != lps_pkg::ST_IDLE && enLowDone
                                |=> q.st == lps_pkg::ST_IDLE && ctrlOut.shutdown)
    else $error("enable-low timeout did not shut down");

endmodule // lps_sequencer

`default_nettype wire

/* src/lps_sync_clock.sv */
// lps_sync_clock: watches the frequency-set/sync pin, picks the switching clock.
// assumes the pin is a digital sample of the pad, asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module lps_sync_clock #(
  parameter int OscDiv = lps_pkg::OSC_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pad
  input  wire logic freqSetSyncPin,
  // status toward the sequencer
  output var  logic switchTick,
  output var  logic extActive,
  output var  logic pinHigh,
  output var  logic pinHeldLow
);

  localparam int DIV_W = lps_pkg::DIV_W;

  lps_pkg::lps_sync_s q;
  lps_pkg::lps_sync_s d;
  logic rise;
  logic intTick;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = freqSetSyncPin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    rise = q.s2 & ~q.s3;
    if (rise) begin
      d.gap = '0;
    end else if (q.gap != lps_pkg::SYNC_GAP_CYC) begin
      d.gap = q.gap + 1'b1;
    end
    // two edges inside the gap lock on; a missing edge drops back
    if (rise && q.gap < lps_pkg::SYNC_GAP_CYC) begin
      d.ext = 1'b1;
    end else if (d.gap == lps_pkg::SYNC_GAP_CYC) begin
      d.ext = 1'b0;
    end
    // divider restarts on loss so the halt is gap plus one period
    intTick = !q.ext && (q.div == DIV_W'(OscDiv - 1));
    if (q.ext || intTick) begin
      d.div = '0;
    end else begin
      d.div = q.div + 1'b1;
    end
    d.tick = q.ext ? rise : intTick;
    if (q.s2) begin
      d.lowCnt = '0;
    end else if (q.lowCnt != lps_pkg::PIN_LOW_CYC) begin
      d.lowCnt = q.lowCnt + 1'b1;
    end
    d.heldLow = (d.lowCnt == lps_pkg::PIN_LOW_CYC);
    d.high = q.s2;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // synchroniser rests at the released pad level, so no false edge follows reset
      q <= '{gap: lps_pkg::SYNC_GAP_CYC, s1: 1'b1, s2: 1'b1, s3: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign switchTick = q.tick;
  assign extActive  = q.ext;
  assign pinHigh    = q.high;
  assign pinHeldLow = q.heldLow;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  localparam int FallbackMax = 200;

  heldLowCause_a: assert property (!pinHeldLow ##1 pinHeldLow |-> !$past(q.s2, 2))
    else $error("held-low flag set while pin high");
  fallBack_a: assert property ($fell(extActive) |-> ##[1:FallbackMax] switchTick)
    else $error("no internal tick after sync loss");

endmodule // lps_sync_clock

`default_nettype wire

/* tb/lps_host_model.sv */
// lps_host_model: host side of the sequencer, drives enable and the freq-set/sync pad.
// assumes clk is the device clock; all pad changes land just after its rising edge.
`timescale 1ns/10ps
`default_nettype none

module lps_host_model (
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic enReq,
  input  wire logic syncRun,
  input  wire logic pullLow,
  // pads
  output var  logic enable,
  output wire logic freqSetSyncPin
);
  // ----------------------------------------------------------------
  // sync source
  // ----------------------------------------------------------------
  // 63 cycles a phase: 252 ns each way, about 2 MHz at 50 % duty
  localparam int HalfCyc = 63;
  logic [6:0] phaseQ = 7'h00;
  logic       syncQ  = 1'b1;
  initial enable = 1'b0;

  always @(posedge clk) begin
    enable <= enReq;
    if (!syncRun) begin
      phaseQ <= 7'h00;
      syncQ  <= 1'b1;
    end else if (phaseQ == 7'(HalfCyc - 1)) begin
      phaseQ <= 7'h00;
      syncQ  <= ~syncQ;
    end else begin
      phaseQ <= phaseQ + 7'h01;
    end
  end

  // a released pad rests high through its resistor, so a stopped clock reads high
  assign freqSetSyncPin = pullLow ? 1'b0 : syncQ;
endmodule // lps_host_model

`default_nettype wire

/* tb/test_lps_sequencer.sv */
// test_lps_sequencer: self-checking bench of the power-up sequencer.
// assumes lps_pkg is compiled first; enable-low count and oscillator divider shortened by parameters.
`timescale 1ns/10ps
`default_nettype none

module test_lps_sequencer;
  localparam int OscDiv = 10;
  localparam int EnLow  = 20;

  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                enReq = 1'b0;
  logic                syncRun = 1'b0;
  logic                pullLow = 1'b1;
  logic                lockOk = 1'b0;
  logic                gateRdy = 1'b0;
  logic                voltsOk = 1'b0;
  logic [3:0]          above = 4'h0;
  logic [3:0]          short = 4'h0;
  logic [3:0]          inUse = 4'h0;
  logic                hostEn;
  wire logic           pin;
  lps_pkg::lps_sense_s sense;
  lps_pkg::lps_ctrl_s  ctrl;
  logic [3:0]          used;
  logic                useExt;
  int                  n_errors = 0;
  int                  check_count = 0;

  always #2 clk = ~clk;
  assign sense = {hostEn, lockOk, gateRdy, voltsOk, above, short, inUse};

  lps_host_model lps_host_model_i (.clk(clk), .enReq(enReq), .syncRun(syncRun),
    .pullLow(pullLow), .enable(hostEn), .freqSetSyncPin(pin));
  lps_sequencer #(.EnLowTicks(EnLow), .OscDiv(OscDiv)) lps_sequencer_i (.clk(clk),
    .rst_n(rst_n), .senseIn(sense), .freqSetSyncPin(pin), .ctrlOut(ctrl),
    .chanUsed(used), .useExternalClock(useExt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // samples one step after the edge so that the edge's updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic countTicks(input int span, output int cnt);
    cnt = 0;
    repeat (span) begin
      cyc(1);
      if (ctrl.switchTick === 1'b1) cnt++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_qualify();
    int k;
    @(posedge clk);
    enReq  <= 1'b1;
    pullLow <= 1'b0;
    cyc(400);
    chk("no supply shutdown", 8'h01, 8'(ctrl.shutdown));
    @(posedge clk);
    lockOk  <= 1'b1;
    pullLow <= 1'b1;
    cyc(400);
    chk("pin low shutdown", 8'h01, 8'(ctrl.shutdown));
    @(posedge clk);
    pullLow <= 1'b0;
    cyc(150);
    chk("gate early", 8'h00, 8'(ctrl.gateDrive));
    for (k = 0; k < 60 && ctrl.gateDrive !== 1'b1; k++) cyc(1);
    chk("gate on", 8'h01, 8'(ctrl.gateDrive));
    cyc(300);
    chk("no sink before check", 8'h00, 8'(ctrl.sinkEnable));
    $display("test_qualify done");
  endtask

  task automatic test_detect();
    int k;
    @(posedge clk);
    gateRdy <= 1'b1;
    above   <= 4'hF;
    short   <= 4'h1;
    inUse   <= 4'hB;
    cyc(3500 * OscDiv + 300);
    chk("short holds sinks", 8'h00, 8'(ctrl.sinkEnable));
    chk("short holds softstart", 8'h00, 8'(ctrl.softstartSinkCurrent));
    @(posedge clk);
    short <= 4'h0;
    cyc(2990 * OscDiv);
    chk("decided early", 8'h00, 8'(ctrl.softstartSinkCurrent));
    for (k = 0; k < 1020 * OscDiv && ctrl.softstartSinkCurrent !== 1'b1; k++) cyc(1);
    chk("softstart current", 8'h01, 8'(ctrl.softstartSinkCurrent));
    chk("softstart limit", 8'h01, 8'(ctrl.softstartSwitchLimit));
    chk("full limit off", 8'h00, 8'(ctrl.fullSwitchLimit));
    chk("channels used", 8'h0B, 8'(used));
    chk("unused sink off", 8'h0B, 8'(ctrl.sinkEnable));
    $display("test_detect done");
  endtask

  task automatic test_regulate();
    int k;
    @(posedge clk);
    voltsOk <= 1'b1;
    for (k = 0; k < 20 && ctrl.fullSwitchLimit !== 1'b1; k++) cyc(1);
    chk("full limit", 8'h01, 8'(ctrl.fullSwitchLimit));
    chk("softstart limit off", 8'h00, 8'(ctrl.softstartSwitchLimit));
    chk("softstart current off", 8'h00, 8'(ctrl.softstartSinkCurrent));
    chk("regulating sinks", 8'h0B, 8'(ctrl.sinkEnable));
    $display("test_regulate done");
  endtask

  task automatic test_sync();
    int k;
    int cnt;
    @(posedge clk);
    syncRun <= 1'b1;
    for (k = 0; k < 400 && useExt !== 1'b1; k++) cyc(1);
    chk("sync locked", 8'h01, 8'(useExt));
    countTicks(1008, cnt);
    chk("ticks follow sync", 8'h01, 8'(cnt >= 7 && cnt <= 9));
    @(posedge clk);
    syncRun <= 1'b0;
    cyc(1);
    for (k = 0; k < 1800 && ctrl.switchTick !== 1'b1; k++) cyc(1);
    chk("halt bounded", 8'h01, 8'(k <= 1750));
    chk("sync dropped", 8'h00, 8'(useExt));
    countTicks(1000, cnt);
    chk("resistor rate", 8'h01, 8'(cnt >= 99 && cnt <= 101));
    $display("test_sync done");
  endtask

  task automatic test_pin_off();
    int k;
    @(posedge clk);
    pullLow <= 1'b1;
    cyc(1700);
    chk("not yet off", 8'h00, 8'(ctrl.shutdown));
    for (k = 0; k < 100 && ctrl.shutdown !== 1'b1; k++) cyc(1);
    chk("pin off shutdown", 8'h01, 8'(ctrl.shutdown));
    chk("pin off gate", 8'h00, 8'(ctrl.gateDrive));
    chk("pin off sinks", 8'h00, 8'(ctrl.sinkEnable));
    chk("pin off switching", 8'h00, 8'(ctrl.switchEnable));
    @(posedge clk);
    voltsOk <= 1'b0;
    pullLow <= 1'b0;
    for (k = 0; k < 20 && ctrl.softstartSinkCurrent !== 1'b1; k++) cyc(1);
    chk("resume softstart", 8'h01, 8'(ctrl.softstartSinkCurrent));
    $display("test_pin_off done");
  endtask

  task automatic test_enable_low();
    int k;
    @(posedge clk);
    enReq <= 1'b0;
    cyc(10);
    chk("dim sinks off", 8'h00, 8'(ctrl.sinkEnable));
    cyc(EnLow * OscDiv - 60);
    chk("still awake", 8'h00, 8'(ctrl.shutdown));
    for (k = 0; k < 100 && ctrl.shutdown !== 1'b1; k++) cyc(1);
    chk("enable low shutdown", 8'h01, 8'(ctrl.shutdown));
    chk("enable low gate", 8'h00, 8'(ctrl.gateDrive));
    $display("test_enable_low done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cyc(5);
    test_qualify();
    test_detect();
    test_regulate();
    test_sync();
    test_pin_off();
    test_enable_low();
    results();
  end

  // the whole run needs about 80k cycles
  initial begin
    #(100000 * 4);
    n_errors++;
    results();
  end
endmodule // test_lps_sequencer

`default_nettype wire
